// ==== core/tbcc_top.sv ====
// two capture/compare channels of timer unit b behind an apb slave
// ============================================================================
`timescale 1ns/1ps
module tbcc_top
(
	input  wire logic        pclk,              // bus clock, 50 MHz
	input  wire logic        presetn,           // async reset, active low
	input  wire logic        psel,              // apb select
	input  wire logic        penable,           // apb access phase
	input  wire logic        pwrite,            // apb write
	input  wire logic [7:0]  paddr,             // apb byte address
	input  wire logic [31:0] pwdata,            // apb write data
	output logic      [31:0] prdata,            // apb read data
	output logic             pready,            // apb ready
	output logic             pslverr,           // apb error, unmapped
	input  wire logic [15:0] counter_value,     // shared timer count
	input  wire logic        counter_wrap,      // overflow pulse
	input  wire logic        counter_halt,      // counter stopped level
	input  wire logic [1:0]  channel_pin_in,    // pin levels, async
	output logic      [1:0]  channel_pin_out,   // pin drive level
	output logic      [1:0]  channel_pin_oe_n   // low while driving pin
);

	// ========================================================================
	// state
	logic             flag_reg     [2];
	logic             arm_reg      [2];
	logic             msa_reg      [2];
	logic [1:0]       els_reg      [2];
	logic             tov_reg      [2];
	logic             max_reg      [2];
	logic             max_eff_reg  [2];
	logic             lock_reg     [2];
	logic             inhib_reg    [2];
	logic             out_reg      [2];
	logic             mprev_reg    [2];
	logic [15:0]      value_reg    [2];
	logic             buf_reg;
	logic             act_sel_reg;
	logic             last_wr_reg;
	logic [31:0]      prdata_reg;
	logic             pready_reg;
	logic             pslverr_reg;
	logic [1:0]       pin_out_reg;
	logic [1:0]       pin_oe_n_reg;

	// ========================================================================
	// decode
	logic             setup;
	logic             wr_acc;
	logic             rd_acc;
	logic             ctrl_hit     [2];
	logic             hi_hit       [2];
	logic             lo_hit       [2];
	logic             active       [2];
	logic             connected    [2];
	logic             cmp_mode     [2];
	logic             cap_mode     [2];
	logic [15:0]      cmp_val      [2];
	logic             match_now    [2];
	logic             match_evt    [2];
	logic             cap_evt      [2];
	logic             trig         [2];
	logic             wrap_tog     [2];
	logic             zero_duty    [2];
	logic             full_duty    [2];
	logic [1:0]       rise;
	logic [1:0]       fall;
	tbcc_pkg::tbcc_mode_e mode     [2];

	tbcc_pin_sync u_sync
	(
		.pclk    (pclk),
		.presetn (presetn),
		.pin_in  (channel_pin_in),
		.rise    (rise),
		.fall    (fall)
	);

	// apb phases; access completes in its first cycle
	assign setup  = psel & ~penable;
	assign wr_acc = psel & penable & pready_reg & pwrite;
	assign rd_acc = psel & penable & pready_reg & ~pwrite;

	assign ctrl_hit[0] = paddr == tbcc_pkg::byte_addr(tbcc_pkg::CH0_CTRL_IDX);
	assign hi_hit[0]   = paddr == tbcc_pkg::byte_addr(tbcc_pkg::CH0_HI_IDX);
	assign lo_hit[0]   = paddr == tbcc_pkg::byte_addr(tbcc_pkg::CH0_LO_IDX);
	assign ctrl_hit[1] = paddr == tbcc_pkg::byte_addr(tbcc_pkg::CH1_CTRL_IDX);
	assign hi_hit[1]   = paddr == tbcc_pkg::byte_addr(tbcc_pkg::CH1_HI_IDX);
	assign lo_hit[1]   = paddr == tbcc_pkg::byte_addr(tbcc_pkg::CH1_LO_IDX);

	// channel 1 is parked while channel 0 runs buffered
	assign active[0] = 1'b1;
	assign active[1] = ~buf_reg;

	// per-channel event decode
	always_comb
	begin
		for (int c = 0; c < 2; c++)
		begin
			mode[c] = tbcc_pkg::chan_mode((c == 0) ? buf_reg : 1'b0,
			                              msa_reg[c]);
			connected[c] = active[c] & (els_reg[c] != tbcc_pkg::ELS_OFF);
			cmp_mode[c]  = active[c] & (mode[c] != tbcc_pkg::MODE_CAPTURE);
			cap_mode[c]  = connected[c] & (mode[c] == tbcc_pkg::MODE_CAPTURE);
			unique case (els_reg[c])
				tbcc_pkg::ELS_ONE:  trig[c] = rise[c];
				tbcc_pkg::ELS_TWO:  trig[c] = fall[c];
				tbcc_pkg::ELS_BOTH: trig[c] = rise[c] | fall[c];
				tbcc_pkg::ELS_OFF:  trig[c] = 1'b0;
			endcase
			// halted counter also inhibits captures
			cap_evt[c] = cap_mode[c] & trig[c] & ~lock_reg[c] &
			             ~counter_halt;
			wrap_tog[c] = cmp_mode[c] & connected[c] & tov_reg[c] &
			              counter_wrap;
			zero_duty[c] = cmp_mode[c] & (els_reg[c] == tbcc_pkg::ELS_TWO) &
			               ~tov_reg[c] & ~max_eff_reg[c];
			full_duty[c] = cmp_mode[c] & (els_reg[c] == tbcc_pkg::ELS_TWO) &
			               tov_reg[c] & max_eff_reg[c];
		end
		// buffered channel 0 compares against the selected register
		cmp_val[0] = (buf_reg && act_sel_reg) ? value_reg[1]
		                                      : value_reg[0];
		cmp_val[1] = value_reg[1];
		for (int c = 0; c < 2; c++)
		begin
			// match counted once as the count arrives at the value
			match_now[c] = counter_value == cmp_val[c];
			match_evt[c] = cmp_mode[c] & match_now[c] & ~mprev_reg[c] &
			               ~inhib_reg[c];
		end
	end

	// ========================================================================
	// apb response: read data and error latched in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_reg  <= 32'h0000_0000;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end
		else
		begin
			pready_reg  <= setup;
			pslverr_reg <= setup & ~(ctrl_hit[0] | hi_hit[0] | lo_hit[0] |
			                         ctrl_hit[1] | hi_hit[1] | lo_hit[1]);
			if (setup)
			begin
				prdata_reg <= 32'h0000_0000;
				for (int c = 0; c < 2; c++)
				begin
					if (ctrl_hit[c])
						prdata_reg[7:0] <= {flag_reg[c], 1'b0,
						                    (c == 0) ? buf_reg : 1'b0,
						                    msa_reg[c], els_reg[c],
						                    tov_reg[c], max_reg[c]};
					if (hi_hit[c])
						prdata_reg[7:0] <= value_reg[c][15:8];
					if (lo_hit[c])
						prdata_reg[7:0] <= value_reg[c][7:0];
				end
			end
		end
	end

	// ========================================================================
	// control bits; channel 1 writes ignored while parked
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			buf_reg <= tbcc_pkg::CTRL_BIT_RST;
			for (int c = 0; c < 2; c++)
			begin
				msa_reg[c] <= tbcc_pkg::CTRL_BIT_RST;
				els_reg[c] <= tbcc_pkg::ELS_RST;
				tov_reg[c] <= tbcc_pkg::CTRL_BIT_RST;
				max_reg[c] <= tbcc_pkg::CTRL_BIT_RST;
			end
		end
		else
		begin
			if (wr_acc && ctrl_hit[0])
				buf_reg <= pwdata[tbcc_pkg::BUF_BIT];
			for (int c = 0; c < 2; c++)
			begin
				if (wr_acc && ctrl_hit[c] && active[c])
				begin
					msa_reg[c] <= pwdata[tbcc_pkg::MSA_BIT];
					els_reg[c] <= pwdata[tbcc_pkg::ELS_HI_BIT:
					                     tbcc_pkg::ELS_LO_BIT];
					tov_reg[c] <= pwdata[tbcc_pkg::TOV_BIT];
					max_reg[c] <= pwdata[tbcc_pkg::MAX_BIT];
				end
			end
		end
	end

	// ========================================================================
	// event flags: set wins over the two-step clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int c = 0; c < 2; c++)
			begin
				flag_reg[c] <= 1'b0;
				arm_reg[c]  <= 1'b0;
			end
		end
		else
		begin
			for (int c = 0; c < 2; c++)
			begin
				if (rd_acc && ctrl_hit[c] && prdata_reg[tbcc_pkg::FLAG_BIT])
					arm_reg[c] <= 1'b1;
				else if (wr_acc && ctrl_hit[c])
					arm_reg[c] <= 1'b0;
				if (match_evt[c] || cap_evt[c])
					flag_reg[c] <= 1'b1;
				else if (wr_acc && ctrl_hit[c] && active[c] && arm_reg[c] &&
				         !pwdata[tbcc_pkg::FLAG_BIT])
					flag_reg[c] <= 1'b0;
			end
		end
	end

	// ========================================================================
	// value registers keep no reset value
	always_ff @(posedge pclk)
	begin
		for (int c = 0; c < 2; c++)
		begin
			if (cap_evt[c])
				value_reg[c] <= counter_value;
			else if (wr_acc && hi_hit[c])
				value_reg[c][15:8] <= pwdata[7:0];
			else if (wr_acc && lo_hit[c])
				value_reg[c][7:0] <= pwdata[7:0];
		end
	end

	// high/low byte coherency: capture lock and compare inhibit
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int c = 0; c < 2; c++)
			begin
				lock_reg[c]  <= 1'b0;
				inhib_reg[c] <= 1'b0;
			end
		end
		else
		begin
			for (int c = 0; c < 2; c++)
			begin
				if (rd_acc && hi_hit[c] && cap_mode[c])
					lock_reg[c] <= 1'b1;
				else if (rd_acc && lo_hit[c])
					lock_reg[c] <= 1'b0;
				if (wr_acc && hi_hit[c] && cmp_mode[c])
					inhib_reg[c] <= 1'b1;
				else if (wr_acc && lo_hit[c])
					inhib_reg[c] <= 1'b0;
			end
		end
	end

	// ========================================================================
	// buffered compare source swaps only at overflow, so no glitch mid-period
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			act_sel_reg <= 1'b0;
			last_wr_reg <= 1'b0;
		end
		else
		begin
			if (wr_acc && lo_hit[0])
				last_wr_reg <= 1'b0;
			else if (wr_acc && lo_hit[1])
				last_wr_reg <= 1'b1;
			if (!buf_reg)
				act_sel_reg <= 1'b0;
			else if (counter_wrap)
				act_sel_reg <= last_wr_reg;
		end
	end

	// ========================================================================
	// channel output level
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int c = 0; c < 2; c++)
			begin
				out_reg[c]     <= 1'b0;
				mprev_reg[c]   <= 1'b0;
				max_eff_reg[c] <= 1'b0;
			end
		end
		else
		begin
			for (int c = 0; c < 2; c++)
			begin
				mprev_reg[c] <= match_now[c];
				// full-duty request waits for the next period boundary
				if (counter_wrap)
					max_eff_reg[c] <= max_reg[c];
				if (!connected[c])
					out_reg[c] <= ~msa_reg[c];
				else if (!cmp_mode[c])
					out_reg[c] <= out_reg[c];
				else if (zero_duty[c])
					out_reg[c] <= 1'b0;
				else if (full_duty[c])
					out_reg[c] <= 1'b1;
				else if (wrap_tog[c])
					out_reg[c] <= ~out_reg[c];
				else if (match_evt[c])
				begin
					unique case (els_reg[c])
						tbcc_pkg::ELS_ONE:  out_reg[c] <= ~out_reg[c];
						tbcc_pkg::ELS_TWO:  out_reg[c] <= 1'b0;
						tbcc_pkg::ELS_BOTH: out_reg[c] <= 1'b1;
						tbcc_pkg::ELS_OFF:  out_reg[c] <= out_reg[c];
					endcase
				end
			end
		end
	end

	// pin driven only in a connected compare mode
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_out_reg  <= 2'h0;
			pin_oe_n_reg <= 2'h3;
		end
		else
		begin
			for (int c = 0; c < 2; c++)
			begin
				pin_out_reg[c]  <= out_reg[c];
				pin_oe_n_reg[c] <= ~(connected[c] & cmp_mode[c]);
			end
		end
	end

	assign prdata           = prdata_reg;
	assign pready           = pready_reg;
	assign pslverr          = pslverr_reg;
	assign channel_pin_out  = pin_out_reg;
	assign channel_pin_oe_n = pin_oe_n_reg;

	// ========================================================================
	// checks
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	parked_pin_a: assert property (buf_reg |=> channel_pin_oe_n[1])
		else $error("channel 1 pin driven in buffered mode");
	preset_level_a: assert property (!connected[0] |=> ##1
		(channel_pin_out[0] == ~$past(msa_reg[0], 2)))
		else $error("preset level wrong");
	capture_load_a: assert property (cap_evt[1] |=>
		(value_reg[1] == $past(counter_value)) && flag_reg[1])
		else $error("capture did not load value and flag");
	wrap_wins_a: assert property (wrap_tog[0] && match_evt[0] &&
		!zero_duty[0] && !full_duty[0] |=>
		out_reg[0] != $past(out_reg[0]))
		else $error("overflow toggle lost to compare");
	flag_keep_a: assert property (flag_reg[0] && wr_acc && ctrl_hit[0] &&
		pwdata[tbcc_pkg::FLAG_BIT] |=> flag_reg[0])
		else $error("writing one cleared flag");
	capture_lock_a: assert property (lock_reg[1] && trig[1] && cap_mode[1] &&
		!wr_acc |=> value_reg[1] == $past(value_reg[1]))
		else $error("capture while high byte locked");
	compare_inhib_a: assert property ($rose(flag_reg[0]) && cmp_mode[0]
		|-> !$past(inhib_reg[0]))
		else $error("compare flag during inhibit");
	zero_duty_a: assert property (zero_duty[0] && connected[0] |=> ##1
		!channel_pin_out[0])
		else $error("zero duty output not low");
	full_duty_a: assert property (full_duty[0] && connected[0] |=> ##1
		channel_pin_out[0])
		else $error("full duty output not high");

endmodule

// ==== core/tbcc_pkg.sv ====
// constants, register map and decode helpers for the timer channel block
package tbcc_pkg;

	// ========================================================================
	// register indexes (byte address is four times the index)
	localparam logic [7:0] CH0_CTRL_IDX = 8'h30;
	localparam logic [7:0] CH0_HI_IDX   = 8'h31;
	localparam logic [7:0] CH0_LO_IDX   = 8'h32;
	localparam logic [7:0] CH1_CTRL_IDX = 8'h33;
	localparam logic [7:0] CH1_HI_IDX   = 8'h34;
	localparam logic [7:0] CH1_LO_IDX   = 8'h35;

	// ========================================================================
	// channel control field positions
	localparam int FLAG_BIT   = 7;
	localparam int BUF_BIT    = 5;
	localparam int MSA_BIT    = 4;
	localparam int ELS_HI_BIT = 3;
	localparam int ELS_LO_BIT = 2;
	localparam int TOV_BIT    = 1;
	localparam int MAX_BIT    = 0;

	// ========================================================================
	// reset values and edge/level codes
	localparam logic       CTRL_BIT_RST = 1'b0;
	localparam logic [1:0] ELS_RST      = 2'h0;
	localparam logic [1:0] ELS_OFF      = 2'h0;
	localparam logic [1:0] ELS_ONE      = 2'h1; // rising / toggle
	localparam logic [1:0] ELS_TWO      = 2'h2; // falling / clear
	localparam logic [1:0] ELS_BOTH     = 2'h3; // either / set

	// ========================================================================
	// channel operating mode
	typedef enum logic [1:0]
	{
		MODE_CAPTURE  = 2'b00,
		MODE_COMPARE  = 2'b01,
		MODE_BUFFERED = 2'b11
	} tbcc_mode_e;

	// byte address of a register index
	function automatic logic [7:0] byte_addr(input logic [7:0] idx);
		return {idx[5:0], 2'b00};
	endfunction

	// mode from the buffered and mode-select-A bits
	function automatic tbcc_mode_e chan_mode(input logic buf_sel,
	                                         input logic msa);
		if (buf_sel)
			return MODE_BUFFERED;
		else if (msa)
			return MODE_COMPARE;
		else
			return MODE_CAPTURE;
	endfunction

endpackage

// ==== core/tbcc_pin_sync.sv ====
// two-stage pin synchroniser with edge detection for both channel pins
`timescale 1ns/1ps
module tbcc_pin_sync
(
	input  wire logic       pclk,    // bus clock
	input  wire logic       presetn, // async reset, active low
	input  wire logic [1:0] pin_in,  // raw pin levels
	output logic      [1:0] rise,    // one-cycle rising edge pulse
	output logic      [1:0] fall     // one-cycle falling edge pulse
);

	logic [1:0] meta_reg;
	logic [1:0] sync_reg;
	logic [1:0] prev_reg;

	// ========================================================================
	// first stage feeds only the second stage
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_reg <= 2'h0;
			sync_reg <= 2'h0;
			prev_reg <= 2'h0;
		end
		else
		begin
			meta_reg <= pin_in;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	// edges seen on the settled copy only
	assign rise = sync_reg & ~prev_reg;
	assign fall = ~sync_reg & prev_reg;

endmodule

// ==== test/tbcc_pin_model.sv ====
// model of the outside circuit on the two channel pins
`timescale 1ns/1ps
module tbcc_pin_model
(
	input  wire logic       pclk,      // bus clock
	input  wire logic [1:0] ext_level, // level the outside circuit wants
	input  wire logic [1:0] pin_out,   // block drive level
	input  wire logic [1:0] pin_oe_n,  // low while the block drives
	output logic      [1:0] pin_in     // resolved wire level
);
	logic [1:0] ext_reg;

	// ========================================================================
	// outside level moves only on an edge and is then held for many clocks,
	// so the pin is settled well before any capture is enabled
	always_ff @(posedge pclk)
		ext_reg <= ext_level;

	// the block's drive wins while enabled; otherwise the outside level
	always_comb
		for (int i = 0; i < 2; i++)
			pin_in[i] = pin_oe_n[i] ? ext_reg[i] : pin_out[i];
endmodule

// ==== test/tb.sv ====
// self-checking bench for the timer channel capture/compare block
`timescale 1ns/1ps
module tb;
	localparam logic [7:0] C0 = tbcc_pkg::CH0_CTRL_IDX;
	localparam logic [7:0] H0 = tbcc_pkg::CH0_HI_IDX;
	localparam logic [7:0] L0 = tbcc_pkg::CH0_LO_IDX;
	localparam logic [7:0] C1 = tbcc_pkg::CH1_CTRL_IDX;
	localparam logic [7:0] H1 = tbcc_pkg::CH1_HI_IDX;
	localparam logic [7:0] L1 = tbcc_pkg::CH1_LO_IDX;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [15:0] counter_value;
	logic        counter_wrap;
	logic        counter_halt;
	logic [1:0]  pin_in;
	logic [1:0]  pin_out;
	logic [1:0]  pin_oe_n;
	logic [1:0]  ext_level;
	logic        lvl;
	int          error_cnt;
	int          checked;

	tbcc_top DUT
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .counter_value(counter_value),
		.counter_wrap(counter_wrap), .counter_halt(counter_halt),
		.channel_pin_in(pin_in), .channel_pin_out(pin_out),
		.channel_pin_oe_n(pin_oe_n)
	);

	tbcc_pin_model pins
	(
		.pclk(pclk), .ext_level(ext_level), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .pin_in(pin_in)
	);

	// ========================================================================
	// clock and watchdog; the tests need well under 5000 cycles
	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	initial
	begin
		#200000;
		error_cnt++;
		complete_run();
	end

	// ========================================================================
	// checks and bus cycles
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// bit 0 pin is compared only while it is driven; channel 1 stays off
	task automatic chk_pin(input logic e_oe, input logic e_out);
		repeat (2) @(posedge pclk);
		chk({13'h0000, pin_oe_n, pin_out[0] & ~e_oe},
		    {13'h0000, 1'b1, e_oe, e_out & ~e_oe});
	endtask

	// one apb transfer; request held until pready is seen at an edge,
	// a slave that never answers is caught by the watchdog
	task automatic apb(input logic wr, input logic [7:0] idx,
	                   input logic [7:0] wd, output logic [31:0] rd,
	                   output logic err);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {idx[5:0], 2'b00};
		pwdata  <= {24'h000000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, idx, d, r, e);
	endtask

	task automatic rd(input logic [7:0] idx, input logic [7:0] exp,
	                  input logic exp_err);
		logic [31:0] r;
		logic        e;
		apb(1'b0, idx, 8'h00, r, e);
		chk({7'h00, e, r[7:0]}, {7'h00, exp_err, exp});
	endtask

	// counter at v for one cycle, with an overflow pulse if w
	task automatic tick(input logic [15:0] v, input logic w);
		counter_value <= v;
		counter_wrap  <= w;
		@(posedge pclk);
		counter_value <= 16'h0000;
		counter_wrap  <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask

	// counter held at v while the channel 1 pin moves to level l
	task automatic cap(input logic [15:0] v, input logic l);
		counter_value <= v;
		ext_level[1]  <= l;
		repeat (8) @(posedge pclk);
	endtask

	task automatic complete_run();
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ========================================================================
	// main sequence
	initial
	begin
		error_cnt = 0;
		checked = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		counter_value = 16'h0000;
		counter_wrap = 1'b0;
		counter_halt = 1'b1; // count stopped for mode changes
		ext_level = 2'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk_pin(1'b1, 1'b0);
		rd(C0, 8'h00, 1'b0);
		rd(C1, 8'h00, 1'b0);
		rd(8'h36, 8'h00, 1'b1);         // unmapped place
		wr(C0, 8'h10);
		chk_pin(1'b1, 1'b0);
		wr(C0, 8'h14);
		chk_pin(1'b0, 1'b0);
		wr(H0, 8'h00);
		wr(L0, 8'h40);
		tick(16'h0040, 1'b0);
		chk_pin(1'b0, 1'b1);
		rd(C0, 8'h94, 1'b0);
		wr(C0, 8'h94);
		rd(C0, 8'h94, 1'b0);
		wr(C0, 8'h14);
		rd(C0, 8'h14, 1'b0);
		wr(C0, 8'h18);
		tick(16'h0040, 1'b0);
		chk_pin(1'b0, 1'b0);
		wr(C0, 8'h1C);
		tick(16'h0040, 1'b0);
		chk_pin(1'b0, 1'b1);
		wr(C0, 8'h1A);
		tick(16'h0000, 1'b1);
		chk_pin(1'b0, 1'b0);
		tick(16'h0040, 1'b1);
		chk_pin(1'b0, 1'b1);
		wr(C0, 8'h1B);
		tick(16'h0040, 1'b0);
		chk_pin(1'b0, 1'b0);
		tick(16'h0000, 1'b1);
		tick(16'h0040, 1'b0);
		chk_pin(1'b0, 1'b1);
		wr(C0, 8'h18);
		tick(16'h0000, 1'b1);
		chk_pin(1'b0, 1'b0);
		rd(C0, 8'h98, 1'b0);
		wr(C0, 8'h18);
		wr(H0, 8'h00);
		tick(16'h0040, 1'b0);
		rd(C0, 8'h18, 1'b0);
		wr(L0, 8'h50);
		tick(16'h0050, 1'b0);
		rd(C0, 8'h98, 1'b0);
		// capture on channel 1: rising edge, then falling edge, then either edge
		wr(C1, 8'h04);
		counter_halt <= 1'b0;
		cap(16'h1234, 1'b1);
		rd(C1, 8'h84, 1'b0);
		rd(H1, 8'h12, 1'b0);
		cap(16'h5678, 1'b0);
		cap(16'h5678, 1'b1);
		rd(L1, 8'h34, 1'b0);
		cap(16'h9ABC, 1'b0);
		cap(16'h9ABC, 1'b1);
		rd(H1, 8'h9A, 1'b0);
		rd(L1, 8'hBC, 1'b0);
		wr(C1, 8'h08);
		cap(16'h1111, 1'b0);
		cap(16'h2222, 1'b1);
		rd(H1, 8'h11, 1'b0);
		rd(L1, 8'h11, 1'b0);
		wr(C1, 8'h0C);
		cap(16'h3333, 1'b0);
		rd(H1, 8'h33, 1'b0);
		rd(L1, 8'h33, 1'b0);
		rd(C1, 8'h8C, 1'b0);
		wr(C1, 8'h20);
		rd(C1, 8'h00, 1'b0);
		// buffered pairing parks channel 1
		counter_halt <= 1'b1;
		wr(C0, 8'h24);
		wr(C1, 8'h14);
		rd(C1, 8'h00, 1'b0);
		tick(16'h0000, 1'b1);
		lvl = pin_out[0];
		tick(16'h0050, 1'b0);
		chk_pin(1'b0, ~lvl);
		// new low byte in channel 1 takes over only after the overflow
		wr(H1, 8'h00);
		wr(L1, 8'h60);
		tick(16'h0050, 1'b0);
		chk_pin(1'b0, 1'b0);
		tick(16'h0000, 1'b1);
		tick(16'h0050, 1'b0);
		chk_pin(1'b0, 1'b0);
		tick(16'h0060, 1'b0);
		chk_pin(1'b0, 1'b1);
		complete_run();
	end
endmodule
